// ---- hdl/sensor_monitor_result_logic.sv ----
// Result buffer, accumulators, window comparator and serial slave
// Function
// [R1] Low-power oscillator when select is 1, high-speed when 0.
// [R2] Slave address from strap at power-up, one of 18h..1Fh, held.
// [R3] Autonomous results go into a 16-bit by 16-word FIFO.
// [R4] Buffer mode starts/stops writing; fill level always readable.
// [R5] Output setting picks channel id and valid flag in each entry.
// [R6] Unfilled entries and reads past the data give zero, valid clear.
// [R7] Busy drops when the sequence completes or abort is set.
// [R8] Each read frame returns buffer words in FIFO order.
// [R9] Reads after the last word or while busy return zeros.
// [R10] Sequence start and reset clear the result buffer.
// [R11] One 16-bit accumulator per channel, only if channel scanned.
// [R12] Each accumulator sums 16 results; count readable during run.
// [R13] Sequence start and reset clear the accumulators.
// [R14] Per-channel low/high thresholds and hysteresis; shared count.
// [R15] Comparator block off after power-up; per-channel enables.
// [R16] Hit counter increments on hit, clears otherwise; flag after N.
// [R17] Flags readable; writing 1 clears, 0 leaves unchanged.
// [R18] Event pin follows flags; threshold mode gates buffer fill.
// [R19] General call address 00h is acknowledged.
// [R20] General call then 06h performs a complete reset.
// [R21] General call then 04h re-reads strap; busy high, others ignored.
// [R22] Codes 09h/0Bh/0Dh/0Fh set high-speed status until STOP.
// [R23] Soft reset keeps flags and address; no strap re-read.
// [R24] Separate hit counters for high and low sides per channel.

// ------------------------------------------------------------------
// Result FIFO
// ------------------------------------------------------------------
module sensor_monitor_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16,
  parameter int LVL_W = 5
) (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  input wire logic clear,
  // Fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // Drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready,
  // Fill level
  output logic [LVL_W-1:0] level
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_q;
  logic [PW-1:0] rd_q;
  logic [LVL_W-1:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready = (cnt_q != LVL_W'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem[rd_q];
  assign level = cnt_q;
  assign push = in_valid && in_ready;
  assign pop = out_ready && out_valid;

  // Storage has no reset; the count decides what is valid
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  // Pointers and count; clear empties the queue at once
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else if (clear) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      wr_q <= push ? wr_q + 1'b1 : wr_q;
      rd_q <= pop ? rd_q + 1'b1 : rd_q;
      cnt_q <= cnt_q + LVL_W'(push) - LVL_W'(pop);
    end
  end
endmodule

// ------------------------------------------------------------------
// Top
// ------------------------------------------------------------------
module sensor_monitor_result_logic (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Serial link pins (open drain data)
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Address strap index
  input wire logic [2:0] addr_strap,
  // Converter side
  input wire logic osc_select,
  output logic osc_low_power,
  input wire logic result_valid,
  input wire logic [sensor_monitor_pkg::RES_W-1:0] result_data,
  input wire logic result_channel,
  // Sequence control
  input wire logic sequence_start_bit,
  input wire logic sequence_abort_bit,
  input wire logic sequence_done,
  input wire logic high_precision,
  input wire logic tag_enable,
  input wire logic [1:0] fifo_operating_mode,
  input wire logic [1:0] scan_channel_enable,
  input wire logic soft_device_reset_bit,
  // Status
  output logic busy,
  output logic high_speed_active_bit,
  output logic [6:0] slave_address,
  output logic [sensor_monitor_pkg::LEVEL_W-1:0] buffer_level,
  output logic buffer_full,
  // Accumulators
  output logic [1:0][sensor_monitor_pkg::ACC_W-1:0] acc_data,
  output logic [1:0][sensor_monitor_pkg::ACC_CNT_W-1:0] acc_count,
  // Window comparator
  input wire logic window_block_enable,
  input wire logic [1:0] window_channel_enable,
  input wire logic [1:0][sensor_monitor_pkg::RES_W-1:0] high_threshold,
  input wire logic [1:0][sensor_monitor_pkg::RES_W-1:0] low_threshold,
  input wire logic [1:0][sensor_monitor_pkg::RES_W-1:0] hysteresis,
  input wire logic [sensor_monitor_pkg::EVT_W-1:0] event_count_setting,
  input wire logic [1:0] low_flag_clear,
  input wire logic [1:0] high_flag_clear,
  output logic [1:0] low_flags,
  output logic [1:0] high_flags,
  output logic alert_out,
  output logic alert_oe
);
  localparam int RW = sensor_monitor_pkg::RES_W;
  localparam int WW = sensor_monitor_pkg::WORD_W;
  localparam int HW = sensor_monitor_pkg::HIT_W;

  logic [2:0] scl_s, sda_s;
  logic [2:0] strap_s0, strap_s1;
  logic scl_rise, scl_fall, start_det, stop_det;
  sensor_monitor_pkg::link_state_t st_q;
  logic [7:0] sh_q, tx_q;
  logic [3:0] cnt_q;
  logic rw_q, gc_q, nack_q, lo_next_q, pop_q, hs_q, oe_q, drive_q;
  logic [WW-1:0] word_q, fifo_dout, rd_word, entry;
  logic fifo_ok, in_ready, fifo_wr;
  logic full_rst_q, restrap_req_q, soft_clr, seq_busy_q, busy_q;
  logic [7:0] restrap_cnt_q;
  logic [6:0] addr_q;
  logic [1:0] hi_hit, lo_hit, hi_set, lo_set, hi_st_q, lo_st_q, newres;
  logic [1:0][HW-1:0] hi_cnt_q, lo_cnt_q;
  logic [1:0] lo_fl_q, hi_fl_q;
  logic alert_q, osc_q;

  // Pin synchronisers: stage 0 feeds only stage 1
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      scl_s <= 3'h7;
      sda_s <= 3'h7;
      strap_s0 <= 3'h0;
      strap_s1 <= 3'h0;
    end else begin
      scl_s <= {scl_s[1:0], scl_in};
      sda_s <= {sda_s[1:0], sda_in};
      strap_s0 <= addr_strap;
      strap_s1 <= strap_s0;
    end
  end
  assign scl_rise = scl_s[1] && !scl_s[2];
  assign scl_fall = !scl_s[1] && scl_s[2];
  assign start_det = !sda_s[1] && sda_s[2] && scl_s[1];
  assign stop_det = sda_s[1] && !sda_s[2] && scl_s[1];

  // Soft clear also follows a complete reset, keeping flags apart
  assign soft_clr = full_rst_q || soft_device_reset_bit; // R23

  // Oscillator choice: 1 picks the low-power source
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) osc_q <= 1'b0;
    else osc_q <= osc_select; // R1
  end

  // Strap capture: counted window after reset, full reset or 04h
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      restrap_cnt_q <= sensor_monitor_pkg::RESTRAP_CYCLES;
      addr_q <= sensor_monitor_pkg::ADDR_BASE;
    end else if (full_rst_q || restrap_req_q) begin
      restrap_cnt_q <= sensor_monitor_pkg::RESTRAP_CYCLES; // R20 R21
    end else if (restrap_cnt_q != 8'h00) begin
      restrap_cnt_q <= restrap_cnt_q - 8'h01;
      if (restrap_cnt_q == 8'h01) begin
        addr_q <= sensor_monitor_pkg::ADDR_BASE | {4'h0, strap_s1}; // R2
      end
    end
  end

  // Sequence busy; strap re-read also shows as busy
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      seq_busy_q <= 1'b0;
      busy_q <= 1'b1;
    end else begin
      if (soft_clr || sequence_done || sequence_abort_bit) begin
        seq_busy_q <= 1'b0; // R7
      end else if (sequence_start_bit) begin
        seq_busy_q <= 1'b1;
      end
      busy_q <= seq_busy_q || (restrap_cnt_q != 8'h00); // R21
    end
  end

  // Buffer entry: tag mode puts channel id and valid in the low bits
  always_comb begin
    entry = '0;
    if (tag_enable) begin // R5
      entry[WW-1:sensor_monitor_pkg::ENT_RES_LSB] = result_data;
      entry[sensor_monitor_pkg::ENT_CH_BIT] = result_channel;
      entry[sensor_monitor_pkg::ENT_VALID_BIT] = 1'b1;
    end else begin
      entry = {4'h0, result_data};
    end
  end
  // Writing stops on its own once the queue is full
  assign fifo_wr = result_valid && seq_busy_q && !high_precision &&
    ((fifo_operating_mode == sensor_monitor_pkg::BUF_FILL_TO_FULL) ||
     ((fifo_operating_mode == sensor_monitor_pkg::BUF_FILL_ON_HIT) &&
      |(hi_hit | lo_hit))); // R4 R18

  sensor_monitor_fifo #(
    .WIDTH(WW),
    .DEPTH(sensor_monitor_pkg::FIFO_DEPTH),
    .LVL_W(sensor_monitor_pkg::LEVEL_W)
  ) u_fifo (
    .clock(clock),
    .resetn(resetn),
    .clear(sequence_start_bit || soft_clr), // R10
    .in_valid(fifo_wr), // R3
    .in_data(entry),
    .in_ready(in_ready),
    .out_valid(fifo_ok),
    .out_data(fifo_dout),
    .out_ready(pop_q),
    .level(buffer_level) // R4
  );
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) buffer_full <= 1'b0;
    else buffer_full <= !in_ready;
  end

  // Reads while busy or past the data give a zero word
  assign rd_word = (fifo_ok && !busy_q) ? fifo_dout : '0; // R6 R9

  // Serial slave; data changes only while the clock line is low
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st_q <= sensor_monitor_pkg::ST_IDLE;
      {sh_q, tx_q, word_q} <= '0;
      cnt_q <= 4'h0;
      {rw_q, gc_q, nack_q, lo_next_q, pop_q, hs_q, oe_q} <= '0;
      {full_rst_q, restrap_req_q} <= 2'b00;
    end else begin
      pop_q <= 1'b0;
      full_rst_q <= 1'b0;
      restrap_req_q <= 1'b0;
      if (start_det) begin
        st_q <= sensor_monitor_pkg::ST_ADDR;
        cnt_q <= 4'h0;
        gc_q <= 1'b0;
        oe_q <= 1'b0;
      end else if (stop_det) begin
        st_q <= sensor_monitor_pkg::ST_IDLE;
        hs_q <= 1'b0; // R22
        oe_q <= 1'b0;
      end else if (scl_rise) begin
        if (st_q == sensor_monitor_pkg::ST_ADDR ||
            st_q == sensor_monitor_pkg::ST_RX) begin
          sh_q <= {sh_q[6:0], sda_s[1]};
          cnt_q <= cnt_q + 4'h1;
        end
        if (st_q == sensor_monitor_pkg::ST_TXACK) nack_q <= sda_s[1];
      end else if (scl_fall) begin
        case (st_q)
          sensor_monitor_pkg::ST_ADDR: begin
            if (cnt_q == sensor_monitor_pkg::BIT_LAST) begin
              cnt_q <= 4'h0;
              if (sh_q[7:1] == addr_q && restrap_cnt_q == 8'h00) begin
                oe_q <= 1'b1;
                rw_q <= sh_q[0];
                st_q <= sensor_monitor_pkg::ST_ACK;
              end else if (sh_q == sensor_monitor_pkg::GC_ADDR) begin
                oe_q <= 1'b1; // R19
                gc_q <= 1'b1;
                rw_q <= 1'b0;
                st_q <= sensor_monitor_pkg::ST_ACK;
              end else begin
                if ((sh_q & sensor_monitor_pkg::HS_MASK) ==
                    sensor_monitor_pkg::HS_MATCH) begin
                  hs_q <= 1'b1; // R22
                end
                st_q <= sensor_monitor_pkg::ST_IDLE;
              end
            end
          end
          sensor_monitor_pkg::ST_RX: begin
            if (cnt_q == sensor_monitor_pkg::BIT_LAST) begin
              cnt_q <= 4'h0;
              oe_q <= 1'b1;
              st_q <= sensor_monitor_pkg::ST_ACK;
              if (gc_q && sh_q == sensor_monitor_pkg::GC_RESET) begin
                full_rst_q <= 1'b1; // R20
              end
              if (gc_q && sh_q == sensor_monitor_pkg::GC_RESTRAP) begin
                restrap_req_q <= 1'b1; // R21
              end
            end
          end
          sensor_monitor_pkg::ST_ACK: begin
            if (rw_q) begin
              word_q <= rd_word; // R8
              pop_q <= fifo_ok && !busy_q;
              tx_q <= rd_word[WW-1:8];
              oe_q <= !rd_word[WW-1];
              lo_next_q <= 1'b1;
              cnt_q <= 4'h1;
              st_q <= sensor_monitor_pkg::ST_TX;
            end else begin
              oe_q <= 1'b0;
              st_q <= sensor_monitor_pkg::ST_RX;
            end
          end
          sensor_monitor_pkg::ST_TX: begin
            if (cnt_q == sensor_monitor_pkg::BIT_LAST) begin
              oe_q <= 1'b0;
              st_q <= sensor_monitor_pkg::ST_TXACK;
            end else begin
              oe_q <= !tx_q[6];
              tx_q <= {tx_q[6:0], 1'b0};
              cnt_q <= cnt_q + 4'h1;
            end
          end
          sensor_monitor_pkg::ST_TXACK: begin
            if (nack_q) begin
              st_q <= sensor_monitor_pkg::ST_IDLE;
            end else begin
              cnt_q <= 4'h1;
              st_q <= sensor_monitor_pkg::ST_TX;
              lo_next_q <= !lo_next_q;
              if (lo_next_q) begin
                tx_q <= word_q[7:0];
                oe_q <= !word_q[7];
              end else begin
                word_q <= rd_word; // R8
                pop_q <= fifo_ok && !busy_q;
                tx_q <= rd_word[WW-1:8];
                oe_q <= !rd_word[WW-1];
              end
            end
          end
          default: st_q <= sensor_monitor_pkg::ST_IDLE;
        endcase
      end
    end
  end

  // Per-channel accumulators and window comparators
  for (genvar c = 0; c < sensor_monitor_pkg::CH_N; c++) begin : g_ch
    assign newres[c] = result_valid && (result_channel == 1'(c));
    // Hysteresis keeps a comparator on until the value backs off
    assign hi_hit[c] = window_block_enable && window_channel_enable[c] &&
      newres[c] && (hi_st_q[c] ?
      ({1'b0, result_data} + {1'b0, hysteresis[c]} >=
       {1'b0, high_threshold[c]}) :
      (result_data > high_threshold[c])); // R14 R15 R16
    assign lo_hit[c] = window_block_enable && window_channel_enable[c] &&
      newres[c] && (lo_st_q[c] ?
      ({1'b0, result_data} <=
       {1'b0, low_threshold[c]} + {1'b0, hysteresis[c]}) :
      (result_data < low_threshold[c])); // R14 R15 R16
    assign hi_set[c] = hi_hit[c] &&
      (hi_cnt_q[c] >= HW'(event_count_setting));
    assign lo_set[c] = lo_hit[c] &&
      (lo_cnt_q[c] >= HW'(event_count_setting));

    // Accumulator runs only for scanned channels, up to 16 results
    always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
        acc_data[c] <= '0;
        acc_count[c] <= '0;
      end else if (sequence_start_bit || soft_clr) begin
        acc_data[c] <= '0; // R13
        acc_count[c] <= '0;
      end else if (high_precision && scan_channel_enable[c] &&
                   newres[c] && seq_busy_q &&
                   acc_count[c] != sensor_monitor_pkg::ACC_TOTAL) begin
        acc_data[c] <= acc_data[c] + {4'h0, result_data}; // R11 R12
        acc_count[c] <= acc_count[c] + 5'h01;
      end
    end

    // Hit counters, one per side so sides do not disturb each other
    always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
        {hi_cnt_q[c], lo_cnt_q[c]} <= '0;
        {hi_st_q[c], lo_st_q[c]} <= 2'b00;
      end else if (soft_clr) begin
        {hi_cnt_q[c], lo_cnt_q[c]} <= '0;
        {hi_st_q[c], lo_st_q[c]} <= 2'b00;
      end else if (newres[c] && window_block_enable &&
                   window_channel_enable[c]) begin
        hi_st_q[c] <= hi_hit[c];
        lo_st_q[c] <= lo_hit[c];
        if (!hi_hit[c]) hi_cnt_q[c] <= '0; // R24
        else if (hi_cnt_q[c] != '1) hi_cnt_q[c] <= hi_cnt_q[c] + 1'b1;
        if (!lo_hit[c]) lo_cnt_q[c] <= '0; // R24
        else if (lo_cnt_q[c] != '1) lo_cnt_q[c] <= lo_cnt_q[c] + 1'b1;
      end
    end
  end

  // Latched flags survive soft reset; a new set beats a clear
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      lo_fl_q <= 2'b00;
      hi_fl_q <= 2'b00;
    end else if (full_rst_q) begin
      lo_fl_q <= 2'b00;
      hi_fl_q <= 2'b00;
    end else begin
      lo_fl_q <= (lo_fl_q & ~low_flag_clear) | lo_set; // R17 R23
      hi_fl_q <= (hi_fl_q & ~high_flag_clear) | hi_set; // R17 R23
    end
  end

  // Event pin pulled low while any enabled flag stands
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      alert_q <= 1'b0;
      drive_q <= 1'b0;
    end else begin
      alert_q <= window_block_enable &&
        |((lo_fl_q | hi_fl_q) & window_channel_enable); // R18
      drive_q <= 1'b0;
    end
  end

  assign sda_out = drive_q;
  assign sda_oe = oe_q;
  assign alert_out = drive_q;
  assign alert_oe = alert_q;
  assign osc_low_power = osc_q;
  assign busy = busy_q;
  assign high_speed_active_bit = hs_q;
  assign slave_address = addr_q;
  assign low_flags = lo_fl_q;
  assign high_flags = hi_fl_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  property p_osc;
    osc_select ##1 osc_select |=> osc_low_power;
  endproperty
  a_osc: assert property (p_osc) else $error("osc select ignored"); // R1
  property p_abort;
    sequence_abort_bit ##1 (restrap_cnt_q == 8'h00) |=> !busy;
  endproperty
  a_abort: assert property (p_abort) else $error("busy after abort"); // R7
  property p_start_clr;
    sequence_start_bit |=> buffer_level == '0 && acc_count == '0;
  endproperty
  a_start_clr: assert property (p_start_clr)
    else $error("start did not clear"); // R10
  property p_level;
    buffer_level <= 5'h10;
  endproperty
  a_level: assert property (p_level) else $error("level too high"); // R3
  property p_acc;
    acc_count[0] <= sensor_monitor_pkg::ACC_TOTAL;
  endproperty
  a_acc: assert property (p_acc) else $error("too many sums"); // R12
  property p_clear;
    high_flag_clear[0] && !hi_set[0] && !full_rst_q |=> !high_flags[0];
  endproperty
  a_clear: assert property (p_clear) else $error("flag not cleared"); // R17
  property p_alert;
    !window_block_enable ##1 !window_block_enable |-> !alert_oe;
  endproperty
  a_alert: assert property (p_alert) else $error("alert while off"); // R18
  property p_hs;
    stop_det |=> !high_speed_active_bit;
  endproperty
  a_hs: assert property (p_hs) else $error("hs after stop"); // R22
  property p_restrap;
    restrap_req_q |=> ##1 busy [*8];
  endproperty
  a_restrap: assert property (p_restrap) else $error("restrap idle"); // R21
endmodule

// ---- hdl/sensor_monitor_pkg.sv ----
// Shared constants and types for the sensor monitor result logic
package sensor_monitor_pkg;
  // ----------------------------------------------------------------
  // Data widths and sizes
  // ----------------------------------------------------------------
  localparam int RES_W = 12;
  localparam int WORD_W = 16;
  localparam int FIFO_DEPTH = 16;
  localparam int LEVEL_W = 5;
  localparam int CH_N = 2;
  localparam int ACC_W = 16;
  localparam int ACC_CNT_W = 5;
  localparam logic [ACC_CNT_W-1:0] ACC_TOTAL = 5'h10;
  localparam int EVT_W = 4;
  localparam int HIT_W = 5;
  // ----------------------------------------------------------------
  // Buffer entry layout (tag mode): result, pad, channel, valid
  // ----------------------------------------------------------------
  localparam int ENT_RES_LSB = 4;
  localparam int ENT_CH_BIT = 1;
  localparam int ENT_VALID_BIT = 0;
  // Buffer operating modes
  localparam logic [1:0] BUF_FILL_TO_FULL = 2'h0;
  localparam logic [1:0] BUF_FILL_ON_HIT = 2'h1;
  // ----------------------------------------------------------------
  // Bus addressing and general call codes
  // ----------------------------------------------------------------
  localparam logic [6:0] ADDR_BASE = 7'h18;
  localparam logic [7:0] GC_ADDR = 8'h00;
  localparam logic [7:0] GC_RESET = 8'h06;
  localparam logic [7:0] GC_RESTRAP = 8'h04;
  localparam logic [7:0] HS_MASK = 8'hF9;
  localparam logic [7:0] HS_MATCH = 8'h09;
  localparam logic [3:0] BIT_LAST = 4'h8;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int RESTRAP_TIME_NS = 1000;
  localparam int RESTRAP_CYC_I =
    (RESTRAP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] RESTRAP_CYCLES = 8'(RESTRAP_CYC_I);
  // Serial slave states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ACK = 3'b010,
    ST_RX = 3'b011,
    ST_TX = 3'b100,
    ST_TXACK = 3'b101
  } link_state_t;
endpackage

// ---- testbench/link_host.sv ----
// Behavioural serial link host that reads result words
module link_host (
  // Link pins
  output logic scl,
  output logic host_oe,
  input wire logic sda_in
);
  timeunit 1ns;
  timeprecision 100ps;
  // -----------------------------------------------------------------
  // Bit slots
  // -----------------------------------------------------------------
  // Clock idles high and stands still between frames
  initial begin
    scl = 1'b1;
    host_oe = 1'b0;
  end
  // One 200 ns slot; data moves only while the clock is low
  task automatic slot(input logic b, output logic r);
    host_oe = !b;
    #50 scl = 1'b1;
    #50 r = sda_in;
    #50 scl = 1'b0;
    #50;
  endtask
  // Read frame: address and read bit, three words, NACK on the last
  task automatic read3(input logic [6:0] a, output logic [47:0] d);
    logic r;
    logic [7:0] ab;
    ab = {a, 1'b1};
    host_oe = 1'b1;
    #100 scl = 1'b0;
    #100;
    for (int i = 7; i >= 0; i--) slot(ab[i], r);
    slot(1'b1, r);
    for (int i = 47; i >= 0; i--) begin
      slot(1'b1, d[i]);
      if (i % 8 == 0) slot(i == 0, r);
    end
    host_oe = 1'b1;
    #100 scl = 1'b1;
    #100 host_oe = 1'b0;
    #100;
  endtask
  // Write frame: address byte and one data byte, each ACKed by the slave
  task automatic write2(input logic [7:0] a, input logic [7:0] b);
    logic r;
    logic [15:0] w;
    w = {a, b};
    host_oe = 1'b1;
    #100 scl = 1'b0;
    #100;
    for (int i = 15; i >= 0; i--) begin
      slot(w[i], r);
      if (i % 8 == 0) slot(1'b1, r);
    end
    host_oe = 1'b1;
    #100 scl = 1'b1;
    #100 host_oe = 1'b0;
    #100;
  endtask
endmodule

// ---- testbench/tb_top.sv ----
// Self-checking bench for the sensor monitor result logic
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock, resetn, scl_in, sda_oe, host_oe, osc_select, osc_low_power;
  logic result_valid, result_channel, sequence_start_bit, sequence_abort_bit;
  logic sequence_done, high_precision, tag_enable, soft_device_reset_bit;
  logic busy, window_block_enable, alert_oe;
  logic [2:0] addr_strap;
  logic [11:0] result_data;
  logic [1:0] fifo_operating_mode, scan_channel_enable, window_channel_enable;
  logic [1:0] low_flag_clear, high_flag_clear, low_flags, high_flags;
  logic [6:0] slave_address;
  logic [4:0] buffer_level;
  logic [1:0][15:0] acc_data;
  logic [1:0][4:0] acc_count;
  logic [1:0][11:0] high_threshold, low_threshold, hysteresis;
  logic [3:0] event_count_setting;
  logic [47:0] rd;
  int error_cnt, checked, cyc;
  // Open drain data line with pull-up
  wire sda_in = !(host_oe | sda_oe);
  sensor_monitor_result_logic dut_u (.sda_out(), .alert_out(),
    .high_speed_active_bit(), .buffer_full(), .*);
  link_host host (.scl(scl_in), .host_oe(host_oe), .sda_in(sda_in));
  // -----------------------------------------------------------------
  // Helpers
  // -----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  // Hang guard: the tests need some 1400 cycles
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      results();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic chk(input string n, input logic [15:0] s, e);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic results();
    if (error_cnt == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // One result pulse, then time for it to settle
  task automatic res(input logic ch, input logic [11:0] v);
    result_valid <= 1'b1;
    result_data <= v;
    result_channel <= ch;
    tick(1);
    result_valid <= 1'b0;
    tick(2);
  endtask
  // -----------------------------------------------------------------
  // Main sequence
  // -----------------------------------------------------------------
  initial begin
    {resetn, osc_select, result_valid, result_channel, result_data} = '0;
    {sequence_start_bit, sequence_abort_bit, sequence_done} = '0;
    {high_precision, tag_enable, soft_device_reset_bit} = '0;
    {fifo_operating_mode, scan_channel_enable, window_block_enable} = '0;
    {window_channel_enable, low_flag_clear, high_flag_clear} = '0;
    {low_threshold, hysteresis} = '0;
    high_threshold = {12'hFFF, 12'h800};
    event_count_setting = 4'h1;
    addr_strap = 3'h3;
    tick(10);
    resetn <= 1'b1;
    for (int i = 0; i < 100 && busy !== 1'b0; i++) tick(1);
    @(negedge clock);
    chk("addr", 16'(slave_address), 16'h001B);
    tick(1);
    osc_select <= 1'b1;
    tick(2);
    @(negedge clock);
    chk("osc", 16'(osc_low_power), 16'h0001);
    tick(1);
    tag_enable <= 1'b1;
    sequence_start_bit <= 1'b1;
    tick(1);
    sequence_start_bit <= 1'b0;
    tick(1);
    res(1'b0, 12'hABC);
    res(1'b1, 12'h123);
    @(negedge clock);
    chk("level", 16'(buffer_level), 16'h0002);
    host.read3(7'h1B, rd);
    chk("busy_read", rd[47:32], 16'h0000);
    tick(1);
    sequence_done <= 1'b1;
    tick(1);
    sequence_done <= 1'b0;
    tick(3);
    @(negedge clock);
    chk("busy", 16'(busy), 16'h0000);
    host.read3(7'h1B, rd);
    chk("word0", rd[47:32], 16'hABC1);
    chk("word1", rd[31:16], 16'h1233);
    chk("word2", rd[15:0], 16'h0000);
    tick(1);
    high_precision <= 1'b1;
    scan_channel_enable <= 2'b01;
    sequence_start_bit <= 1'b1;
    tick(1);
    sequence_start_bit <= 1'b0;
    tick(1);
    repeat (16) res(1'b0, 12'h0FF);
    res(1'b1, 12'h0FF);
    @(negedge clock);
    chk("acc0", acc_data[0], 16'h0FF0);
    chk("cnt0", 16'(acc_count[0]), 16'h0010);
    chk("acc1", acc_data[1], 16'h0000);
    tick(1);
    sequence_start_bit <= 1'b1;
    tick(1);
    sequence_start_bit <= 1'b0;
    high_precision <= 1'b0;
    window_block_enable <= 1'b1;
    window_channel_enable <= 2'b01;
    fifo_operating_mode <= 2'h1;
    tick(2);
    @(negedge clock);
    chk("cnt_clr", 16'(acc_count[0]), 16'h0000);
    tick(1);
    // A miss must stay out of the buffer in fill-on-hit mode
    res(1'b0, 12'h100);
    res(1'b0, 12'h900);
    @(negedge clock);
    chk("hit1", 16'(high_flags), 16'h0000);
    tick(1);
    res(1'b0, 12'h900);
    @(negedge clock);
    chk("hit2", 16'(high_flags), 16'h0001);
    chk("pin", 16'(alert_oe), 16'h0001);
    chk("fill", 16'(buffer_level), 16'h0002);
    // Abort ends the running sequence
    tick(1);
    sequence_abort_bit <= 1'b1;
    tick(1);
    sequence_abort_bit <= 1'b0;
    tick(3);
    @(negedge clock);
    chk("abort", 16'(busy), 16'h0000);
    tick(1);
    soft_device_reset_bit <= 1'b1;
    tick(1);
    soft_device_reset_bit <= 1'b0;
    tick(2);
    @(negedge clock);
    chk("kept", 16'(high_flags), 16'h0001);
    chk("addr_kept", 16'(slave_address), 16'h001B);
    tick(1);
    high_flag_clear <= 2'b01;
    tick(1);
    high_flag_clear <= 2'b00;
    tick(2);
    @(negedge clock);
    chk("cleared", 16'(high_flags), 16'h0000);
    chk("pin_off", 16'(alert_oe), 16'h0000);
    // General call 04h re-reads a changed strap; busy stands meanwhile
    tick(1);
    addr_strap <= 3'h5;
    @(negedge clock);
    host.write2(8'h00, 8'h04);
    @(negedge clock);
    chk("restrap_busy", 16'(busy), 16'h0001);
    tick(30);
    @(negedge clock);
    chk("restrap_idle", 16'(busy), 16'h0000);
    chk("new_addr", 16'(slave_address), 16'h001D);
    results();
  end
endmodule
